// *** hw/odt_pkg.sv ***
// Shared constants and types for the termination control block
package odt_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MR1    = 8'h00;
  localparam logic [7:0] OFS_MR2    = 8'h04;
  localparam logic [7:0] OFS_MR5    = 8'h08;
  localparam logic [7:0] OFS_LAT    = 8'h0C;
  localparam logic [7:0] OFS_CFG    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // Mode register field positions
  localparam int MR1_NOM_LSB  = 8;
  localparam int MR2_WR_LSB   = 9;
  localparam int MR2_DYN_A9   = 9;
  localparam int MR2_DYN_A10  = 10;
  localparam int MR5_PARK_LSB = 6;
  // Latency register byte fields
  localparam int LAT_CWL_LSB = 0;
  localparam int LAT_AL_LSB  = 8;
  localparam int LAT_PL_LSB  = 16;
  localparam int LAT_CL_LSB  = 24;
  // Config register bits
  localparam int CFG_PRE2    = 0;
  localparam int CFG_CRC     = 1;
  localparam int CFG_DLL_OFF = 2;
  localparam int CFG_BC4     = 3;
  // Reset values
  localparam logic [15:0] MR_RST  = 16'h0000;
  localparam logic [31:0] LAT_RST = 32'h0000_0000;
  localparam logic [3:0]  CFG_RST = 4'h0;
  // Depth of the command clock history
  localparam int HIST = 64;
  // Clock rate and asynchronous termination window
  localparam int CLK_MHZ      = 125;
  localparam int AONAS_MIN_NS = 2;
  localparam int AONAS_MAX_NS = 12;
  localparam int AOFAS_MIN_NS = 2;
  localparam int AOFAS_MAX_NS = 12;
  localparam int AON_CYC_I    = (AONAS_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int AOF_CYC_I    = (AOFAS_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] AON_CYC = 8'((AON_CYC_I < 1) ? 1 : AON_CYC_I);
  localparam logic [7:0] AOF_CYC = 8'((AOF_CYC_I < 1) ? 1 : AOF_CYC_I);
  // Latency offsets
  localparam logic [9:0] PRE1_SUB = 10'h002;
  localparam logic [9:0] PRE2_SUB = 10'h003;
  localparam logic [7:0] RD_BL8   = 8'h04;
  localparam logic [7:0] RD_BC4   = 8'h02;
  localparam logic [7:0] RD_PRE1  = 8'h02;
  localparam logic [7:0] RD_PRE2  = 8'h03;
  // Write termination length after turn-on
  localparam logic [7:0] CWN4_P1    = 8'h04;
  localparam logic [7:0] CWN8_P1    = 8'h06;
  localparam logic [7:0] CWN_P1_CRC = 8'h07;
  localparam logic [7:0] CWN4_P2    = 8'h05;
  localparam logic [7:0] CWN8_P2    = 8'h07;
  localparam logic [7:0] CWN_P2_CRC = 8'h08;

  typedef enum logic [1:0] {RTT_OFF, RTT_PARK, RTT_NOM, RTT_WR} rtt_mode_t;

  typedef struct packed {
    logic ck;
    logic odt;
    logic wr;
    logic rd;
    logic bc4;
  } pins_t;

  typedef struct packed {
    pins_t            s1;
    pins_t            s2;
    logic             ck_d;
    logic [HIST-1:0]  odt_h;
    logic [HIST-1:0]  wr_h;
    logic [HIST-1:0]  rd_h;
    logic [HIST-1:0]  bc4_h;
    logic [7:0]       wr_rem;
    logic [7:0]       rd_rem;
    logic [7:0]       as_cnt;
    logic             as_odt;
    logic [15:0]      mr1;
    logic [15:0]      mr2;
    logic [15:0]      mr5;
    logic [31:0]      lat;
    logic [3:0]       cfg;
    rtt_mode_t        mode;
    logic [2:0]       code;
    logic             ack;
    logic [31:0]      dat;
  } state_t;
endpackage

// *** hw/odt_control.sv ***
// On-die termination control with a Wishbone register port
// Functional notes
// - No termination while driving read data
// - MR2 A9 or A10 enables dynamic switching
// - Nominal strength from MR1 bits 10:8
// - Write strength from MR2 bits 11:9
// - Park strength from MR5 bits 8:6
// - ODT pin drives nominal, park when low
// - Any write selects write termination after ODTLcnw
// - Write termination ends per burst length
// - ODTLcnw is WL minus two or three
// - End offsets follow preamble and CRC matrix
// - No dynamic switching with DLL off
// - DLL off: ODT pin direct, no AL/PL
// - Async turn-on within tAONAS window
// - Async turn-off within tAOFAS window
// - Read disables termination at RL minus 2/3
// - ODT latency is CWL+AL+PL minus 2/3
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
module odt_control (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Memory controller pins
  input  wire logic        ck_i,
  input  wire logic        odt_i,
  input  wire logic        cmd_wr_i,
  input  wire logic        cmd_rd_i,
  input  wire logic        cmd_bc4_i,
  // Termination result
  output logic      [1:0]  rtt_mode_o,
  output logic      [2:0]  rtt_code_o
);

  odt_pkg::state_t r;
  odt_pkg::state_t n;

  // Latency minus preamble offset, clamped to the history
  function automatic logic [5:0] back(input logic [9:0] lat, input logic pre2);
    logic [9:0] sub;
    logic [9:0] v;
    sub = pre2 ? odt_pkg::PRE2_SUB : odt_pkg::PRE1_SUB;
    v   = (lat > sub) ? lat - sub : 10'h000;
    back = (v > 10'(odt_pkg::HIST - 1)) ? 6'(odt_pkg::HIST - 1) : v[5:0];
  endfunction

  // Write termination length after turn-on, preamble and CRC matrix
  function automatic logic [7:0] cwn(input logic bc4, input logic pre2, input logic crc);
    logic [1:0] k;
    k = {pre2, crc};
    case (k)
      2'b00:
      begin
        if (bc4)
        begin
          cwn = odt_pkg::CWN4_P1;
        end
        else
        begin
          cwn = odt_pkg::CWN8_P1;
        end
      end
      2'b01:
      begin
        cwn = odt_pkg::CWN_P1_CRC;
      end
      2'b10:
      begin
        if (bc4)
        begin
          cwn = odt_pkg::CWN4_P2;
        end
        else
        begin
          cwn = odt_pkg::CWN8_P2;
        end
      end
      default:
      begin
        cwn = odt_pkg::CWN_P2_CRC;
      end
    endcase
  endfunction

  // Read disable length: half burst plus preamble and CRC share
  function automatic logic [7:0] rdlen(input logic bc4, input logic pre2, input logic crc);
    logic [7:0] half;
    logic [7:0] pre;
    if (bc4)
    begin
      half = odt_pkg::RD_BC4;
    end
    else
    begin
      half = odt_pkg::RD_BL8;
    end
    if (pre2)
    begin
      pre = odt_pkg::RD_PRE2;
    end
    else
    begin
      pre = odt_pkg::RD_PRE1;
    end
    rdlen = half + pre + {7'h00, crc};
  endfunction

  // Byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // Sum of three latency bytes
  function automatic logic [9:0] sum3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    sum3 = 10'(a) + 10'(b) + 10'(c);
  endfunction

  logic        tick;
  logic        pre2;
  logic        crc;
  logic        dll_off;
  logic        bc4_now;
  logic        dyn;
  logic [9:0]  wl;
  logic [9:0]  rl;
  logic [5:0]  dodtl;
  logic [5:0]  rodtl;
  logic        nom_on;
  logic [2:0]  nom_code;
  logic [2:0]  wr_code;
  logic [2:0]  park_code;
  logic [7:0]  as_need;
  logic        bus_req;
  logic [31:0] rdata;

  always_comb
  begin
    n = r;
    // Pin synchronisers
    n.s1   = '{ck: ck_i, odt: odt_i, wr: cmd_wr_i, rd: cmd_rd_i, bc4: cmd_bc4_i};
    n.s2   = r.s1;
    n.ck_d = r.s2.ck;
    tick   = r.s2.ck & ~r.ck_d;

    pre2      = r.cfg[odt_pkg::CFG_PRE2];
    crc       = r.cfg[odt_pkg::CFG_CRC];
    dll_off   = r.cfg[odt_pkg::CFG_DLL_OFF];
    bc4_now   = r.cfg[odt_pkg::CFG_BC4] | r.s2.bc4;
    nom_code  = r.mr1[odt_pkg::MR1_NOM_LSB +: 3];
    wr_code   = r.mr2[odt_pkg::MR2_WR_LSB +: 3];
    park_code = r.mr5[odt_pkg::MR5_PARK_LSB +: 3];
    // Dynamic switching, off once MR2 bits A9 and A10 are both clear or DLL is off
    dyn = (r.mr2[odt_pkg::MR2_DYN_A9] | r.mr2[odt_pkg::MR2_DYN_A10])
          & ~dll_off;

    wl = sum3(r.lat[odt_pkg::LAT_CWL_LSB +: 8], r.lat[odt_pkg::LAT_AL_LSB +: 8],
              r.lat[odt_pkg::LAT_PL_LSB +: 8]);
    rl = sum3(r.lat[odt_pkg::LAT_CL_LSB +: 8], r.lat[odt_pkg::LAT_AL_LSB +: 8],
              r.lat[odt_pkg::LAT_PL_LSB +: 8]);
    dodtl = back(wl, pre2);
    rodtl = back(rl, pre2);

    // Command clock timeline
    if (tick)
    begin
      n.odt_h = {r.odt_h[odt_pkg::HIST-2:0], r.s2.odt};
      n.wr_h  = {r.wr_h[odt_pkg::HIST-2:0], r.s2.wr & dyn};
      n.rd_h  = {r.rd_h[odt_pkg::HIST-2:0], r.s2.rd};
      n.bc4_h = {r.bc4_h[odt_pkg::HIST-2:0], bc4_now};
      // Write termination window
      if (n.wr_h[dodtl])
      begin
        n.wr_rem = cwn(n.bc4_h[dodtl], pre2, crc);
      end
      else if (r.wr_rem != 8'h00)
      begin
        n.wr_rem = r.wr_rem - 8'h01;
      end
      // Read disable window
      if (n.rd_h[rodtl])
      begin
        n.rd_rem = rdlen(n.bc4_h[rodtl], pre2, crc);
      end
      else if (r.rd_rem != 8'h00)
      begin
        n.rd_rem = r.rd_rem - 8'h01;
      end
    end

    // Asynchronous mode follows the pin after a fixed settle
    as_need = r.as_odt ? odt_pkg::AOF_CYC : odt_pkg::AON_CYC;
    if (dll_off && (r.s2.odt != r.as_odt))
    begin
      if (r.as_cnt >= as_need - 8'h01)
      begin
        n.as_odt = r.s2.odt;
        n.as_cnt = 8'h00;
      end
      else
      begin
        n.as_cnt = r.as_cnt + 8'h01;
      end
    end
    else
    begin
      n.as_odt = dll_off ? r.as_odt : r.s2.odt;
      n.as_cnt = 8'h00;
    end

    nom_on = dll_off ? r.as_odt : r.odt_h[dodtl];

    // Termination priority: read, write, nominal, park
    if (r.rd_rem != 8'h00)
    begin
      n.mode = odt_pkg::RTT_OFF;
      n.code = 3'h0;
    end
    else if ((r.wr_rem != 8'h00) && (wr_code != 3'h0))
    begin
      n.mode = odt_pkg::RTT_WR;
      n.code = wr_code;
    end
    else if (nom_on && (nom_code != 3'h0))
    begin
      n.mode = odt_pkg::RTT_NOM;
      n.code = nom_code;
    end
    else if (park_code != 3'h0)
    begin
      n.mode = odt_pkg::RTT_PARK;
      n.code = park_code;
    end
    else
    begin
      n.mode = odt_pkg::RTT_OFF;
      n.code = 3'h0;
    end

    // Register read mux
    case (wb_adr_i)
      odt_pkg::OFS_MR1:
      begin
        rdata = {16'h0000, r.mr1};
      end
      odt_pkg::OFS_MR2:
      begin
        rdata = {16'h0000, r.mr2};
      end
      odt_pkg::OFS_MR5:
      begin
        rdata = {16'h0000, r.mr5};
      end
      odt_pkg::OFS_LAT:
      begin
        rdata = r.lat;
      end
      odt_pkg::OFS_CFG:
      begin
        rdata = {28'h000_0000, r.cfg};
      end
      odt_pkg::OFS_STATUS:
      begin
        rdata = {26'h000_0000, (r.wr_rem != 8'h00), (r.rd_rem != 8'h00),
                 nom_on, r.code[0], r.mode};
      end
      default:
      begin
        rdata = 32'h0000_0000;
      end
    endcase

    // Single-cycle Wishbone answer
    bus_req = wb_cyc_i & wb_stb_i & ~r.ack;
    n.ack   = bus_req;
    n.dat   = bus_req ? rdata : 32'h0000_0000;
    if (bus_req && wb_we_i)
    begin
      case (wb_adr_i)
        odt_pkg::OFS_MR1:
        begin
          n.mr1 = 16'(merge({16'h0000, r.mr1}, wb_dat_i, wb_sel_i));
        end
        odt_pkg::OFS_MR2:
        begin
          n.mr2 = 16'(merge({16'h0000, r.mr2}, wb_dat_i, wb_sel_i));
        end
        odt_pkg::OFS_MR5:
        begin
          n.mr5 = 16'(merge({16'h0000, r.mr5}, wb_dat_i, wb_sel_i));
        end
        odt_pkg::OFS_LAT:
        begin
          n.lat = merge(r.lat, wb_dat_i, wb_sel_i);
        end
        odt_pkg::OFS_CFG:
        begin
          n.cfg = 4'(merge({28'h000_0000, r.cfg}, wb_dat_i, wb_sel_i));
        end
        default:
        begin
          n.cfg = r.cfg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r        <= '0;
      r.mr1    <= odt_pkg::MR_RST;
      r.mr2    <= odt_pkg::MR_RST;
      r.mr5    <= odt_pkg::MR_RST;
      r.lat    <= odt_pkg::LAT_RST;
      r.cfg    <= odt_pkg::CFG_RST;
      r.mode   <= odt_pkg::RTT_OFF;
    end
    else
    begin
      r <= n;
    end
  end

  assign wb_dat_o   = r.dat;
  assign wb_ack_o   = r.ack;
  assign rtt_mode_o = r.mode;
  assign rtt_code_o = r.code;

endmodule

// *** verif/odt_control_asserts.sv ***
// Port checker for the termination control block
`timescale 1ns/1ps
module odt_control_asserts (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Termination
  input wire logic [1:0]  rtt_mode_o,
  input wire logic [2:0]  rtt_code_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack missing");
  property p_ack_src; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack without request");
  property p_dat_idle; wb_dat_o != 32'h0000_0000 |-> wb_ack_o; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_rst; $past(rst_i) |-> rtt_mode_o == 2'h0 && !wb_ack_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_off; rtt_mode_o == 2'h0 |-> rtt_code_o == 3'h0; endproperty
  a_off: assert property (p_off) else $error("code while off");
  property p_nom; rtt_mode_o == 2'h2 |-> rtt_code_o != 3'h0; endproperty
  a_nom: assert property (p_nom) else $error("nominal with zero code");
  property p_wr; rtt_mode_o == 2'h3 |-> rtt_code_o != 3'h0; endproperty
  a_wr: assert property (p_wr) else $error("write with zero code");
  property p_park; rtt_mode_o == 2'h1 |-> rtt_code_o != 3'h0; endproperty
  a_park: assert property (p_park) else $error("park with zero code");
endmodule
bind odt_control odt_control_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rtt_mode_o(rtt_mode_o), .rtt_code_o(rtt_code_o));

// *** verif/odt_ctl_model.sv ***
// Memory controller model: command clock, ODT level and command pins
`timescale 1ns/1ps
module odt_ctl_model (
  // Clock
  input  wire logic clk_i,
  // Controller pins
  output logic      ck_o,
  output logic      odt_o,
  output logic      wr_o,
  output logic      rd_o,
  output logic      bc4_o
);
  initial
  begin
    {ck_o, odt_o, wr_o, rd_o, bc4_o} = 5'h00;
    forever #80 ck_o = ~ck_o;
  end
  // Command valid for one tick, odt level kept until next call
  task automatic drive(input logic o, input logic w, input logic r, input logic b);
    @(negedge ck_o);
    @(posedge clk_i);
    odt_o <= o;
    {wr_o, rd_o, bc4_o} <= {w, r, b};
    @(negedge ck_o);
    @(posedge clk_i);
    {wr_o, rd_o, bc4_o} <= 3'h0;
  endtask
endmodule

// *** verif/odt_control_tb.sv ***
// Self-checking bench for the termination control block
`timescale 1ns/1ps
module odt_control_tb;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        ck_i, odt_i, cmd_wr_i, cmd_rd_i, cmd_bc4_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_v;
  logic [1:0]  rtt_mode_o;
  logic [2:0]  rtt_code_o;
  int          num_errors, checks_done;
  int          d4[4] = '{4, 7, 5, 8};
  int          d8[4] = '{6, 7, 7, 8};
  odt_control u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ck_i(ck_i), .odt_i(odt_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i),
    .cmd_bc4_i(cmd_bc4_i), .rtt_mode_o(rtt_mode_o), .rtt_code_o(rtt_code_o));
  odt_ctl_model u_ctl (
    .clk_i(clk_i), .ck_o(ck_i), .odt_o(odt_i), .wr_o(cmd_wr_i), .rd_o(cmd_rd_i), .bc4_o(cmd_bc4_i));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cm(input logic [4:0] exp);
    chk(32'({rtt_mode_o, rtt_code_o}), 32'(exp));
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 9);
    if (n >= 9)
    begin
      num_errors++;
      conclude();
    end
    rd_v = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge ck_i);
  endtask
  task automatic t_regs();
    wb(1'b0, odt_pkg::OFS_MR2, 32'h0000_0000);
    chk(rd_v, 32'h0000_0000);
    wb(1'b1, odt_pkg::OFS_MR1, 32'hFFFF_0300);
    wb(1'b0, odt_pkg::OFS_MR1, 32'h0000_0000);
    chk(rd_v, 32'h0000_0300);
    wb(1'b1, odt_pkg::OFS_MR5, 32'h0000_0140);
    wb(1'b1, 8'h18, 32'h0000_FFFF);
    wb(1'b0, 8'h18, 32'h0000_0000);
    chk(rd_v, 32'h0000_0000);
    $display("regs done");
  endtask
  task automatic t_nom();
    wb(1'b1, odt_pkg::OFS_LAT, 32'h0001_0209);
    for (int p = 0; p < 2; p++)
    begin
      wb(1'b1, odt_pkg::OFS_CFG, 32'(p));
      u_ctl.drive(1'b1, 1'b0, 1'b0, 1'b0);
      tk(9 - p);
      cm(5'h0D);
      tk(1);
      cm(5'h13);
      u_ctl.drive(1'b0, 1'b0, 1'b0, 1'b0);
      tk(9 - p);
      cm(5'h13);
      tk(1);
      cm(5'h0D);
    end
    $display("nominal done");
  endtask
  task automatic t_wr();
    logic [2:0] b;
    int         c;
    int         d;
    wb(1'b1, odt_pkg::OFS_MR2, 32'h0000_0600);
    for (int i = 0; i < 8; i++)
    begin
      b = 3'(i);
      c = b[0] ? 9 : 10;
      d = b[2] ? d4[{b[0], b[1]}] : d8[{b[0], b[1]}];
      wb(1'b1, odt_pkg::OFS_CFG, {28'h000_0000, b[2] & b[0], 1'b0, b[1:0]});
      u_ctl.drive(1'b0, 1'b1, 1'b0, b[2] & ~b[0]);
      tk(c - 1);
      cm(5'h0D);
      tk(1);
      cm(5'h1B);
      tk(d - 1);
      cm(5'h1B);
      tk(1);
      cm(5'h0D);
    end
    $display("write done");
  endtask
  task automatic t_dyn();
    wb(1'b1, odt_pkg::OFS_CFG, 32'h0000_0000);
    for (int k = 0; k < 4; k++)
    begin
      wb(1'b1, odt_pkg::OFS_MR2, 32'h0000_0200 << k);
      u_ctl.drive(1'b0, 1'b1, 1'b0, 1'b0);
      tk(10);
      cm(k < 2 ? {2'h3, 3'(k + 1)} : 5'h0D);
      tk(7);
    end
    $display("dynamic done");
  endtask
  task automatic t_rd();
    wb(1'b1, odt_pkg::OFS_LAT, 32'h0B01_0209);
    u_ctl.drive(1'b1, 1'b0, 1'b0, 1'b0);
    tk(12);
    for (int p = 0; p < 2; p++)
    begin
      wb(1'b1, odt_pkg::OFS_CFG, 32'(3 * p));
      u_ctl.drive(1'b1, 1'b0, 1'b1, 1'b0);
      tk(11 - p);
      cm(5'h13);
      tk(1);
      cm(5'h00);
      tk(5 + 2 * p);
      cm(5'h00);
      tk(1);
      cm(5'h13);
    end
    u_ctl.drive(1'b0, 1'b0, 1'b0, 1'b0);
    tk(12);
    $display("read done");
  endtask
  task automatic t_as();
    wb(1'b1, odt_pkg::OFS_MR2, 32'h0000_0600);
    wb(1'b1, odt_pkg::OFS_CFG, 32'h0000_0004);
    u_ctl.drive(1'b1, 1'b0, 1'b0, 1'b0);
    cm(5'h13);
    tk(7);
    u_ctl.drive(1'b0, 1'b1, 1'b0, 1'b0);
    cm(5'h0D);
    tk(10);
    cm(5'h0D);
    $display("async done");
  endtask
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    num_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_nom();
    t_wr();
    t_dyn();
    t_rd();
    t_as();
    conclude();
  end
endmodule
